// File: rtl/hp_amp_pkg.sv
// Register map, field positions and reset values of the headphone amplifier control bank
package hp_amp_pkg;
	localparam int CHANNELS = 2;
	localparam int CH_LEFT = 0;
	localparam int CH_RIGHT = 1;
	localparam logic [7:0] ADDR_LEFT_CTRL = 8'hD0;
	localparam logic [7:0] ADDR_LEFT_GAIN = 8'hD1;
	localparam logic [7:0] ADDR_RIGHT_CTRL = 8'hD2;
	localparam logic [7:0] ADDR_RIGHT_GAIN = 8'hD3;
	localparam logic [7:0] ADDR_DETECT = 8'hD4;
	localparam logic [7:0] ADDR_MODE = 8'hD5;
	localparam logic [7:0] ADDR_UNLOCK = 8'hD7;
	localparam int BIT_POWER = 7;
	localparam int BIT_SILENCE = 6;
	localparam int BIT_STEPPING = 5;
	localparam int BIT_CROSSING = 4;
	localparam int BIT_DRIVE = 3;
	localparam int BIT_FLOOR = 2;
	localparam logic [7:0] CTRL_MASK = 8'hFC;
	localparam logic [7:0] CTRL_RESET = 8'h40;
	localparam logic [5:0] GAIN_RESET = 6'h3B;
	localparam logic [5:0] GAIN_MIN = 6'h15;
	localparam logic [5:0] GAIN_STEP = 6'h01;
	localparam int BIT_STEREO_SENSE = 7;
	localparam int BIT_LOAD_SENSE = 6;
	localparam int BIT_RIGHT_LOAD = 2;
	localparam int BIT_LEFT_LOAD = 1;
	localparam int BIT_STEREO_STATUS = 0;
	localparam int BIT_ONE_RAIL = 4;
	localparam int BIT_BALANCED = 0;
	localparam int BIT_UNLOCKED = 0;
	localparam logic [7:0] UNLOCK_KEY = 8'hC3;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage : hp_amp_pkg

// File: rtl/headphone_amp_control_regs.sv
// Headphone amplifier control register bank with gain stepping and zero-cross update
`timescale 1ns/1ps
// Notes on behaviour
// - Control bit 7 switches the channel amplifier on when set and off when clear, off after reset.
// - Control bit 6 silences the channel when set and resets set, so both channels start silenced.
// - With bit 5 set a new gain code is reached by stepping from the old applied gain, not by a jump.
// - When stepping and zero-cross are both set, stepping is used and zero-cross is ignored.
// - With bit 4 set and stepping clear, a pending gain change is applied only at an audio zero crossing.
// - With stepping and zero-cross both clear, a written gain code is applied at once.
// - Control bit 3 drives the output when set and leaves it high impedance when clear, clear after reset.
// - Control bit 2 holds the applied gain at its minimum code whatever the gain register says.
// - The right control register has the same six bits in the same places and gain sits in the low six bits.
// - Gain codes are 1.5 dB steps with 0x15 the lowest usable code, 0x3B 0 dB and 0x3F +6 dB.
// - The one-rail enable accepts a write only after the key 0xC3 was written to the unlock register.
// - Load and stereo detect status bits are read-only and show the sensed load state.
// - Mode bit 0 selects a balanced output when set and a single-ended output when clear.
module headphone_amp_control_regs
	import hp_amp_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic sample_tick,
	input wire logic left_zero_cross,
	input wire logic right_zero_cross,
	input wire logic left_load_pin,
	input wire logic right_load_pin,
	input wire logic stereo_pin,
	output logic left_amp_power,
	output logic left_amp_silence,
	output logic left_output_drive,
	output logic [5:0] left_gain_applied,
	output logic right_amp_power,
	output logic right_amp_silence,
	output logic right_output_drive,
	output logic [5:0] right_gain_applied,
	output logic load_sense_on,
	output logic stereo_sense_on,
	output logic one_rail_operation,
	output logic balanced_output_select
);
	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0] ctrl [CHANNELS];
	logic [7:0] next_ctrl [CHANNELS];
	logic [5:0] gain_code [CHANNELS];
	logic [5:0] next_gain_code [CHANNELS];
	logic [5:0] applied [CHANNELS];
	logic [5:0] next_applied [CHANNELS];
	logic [5:0] out_gain [CHANNELS];
	logic [5:0] next_out_gain [CHANNELS];
	logic pending [CHANNELS];
	logic next_pending [CHANNELS];
	logic [1:0] sense_en;
	logic [1:0] next_sense_en;
	logic one_rail;
	logic next_one_rail;
	logic balanced;
	logic next_balanced;
	logic unlocked;
	logic next_unlocked;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	logic [CHANNELS-1:0] crossing;

	assign crossing = {right_zero_cross, left_zero_cross};

	// ****************************************************************
	// Address decode
	// ****************************************************************
	function automatic logic is_ctrl(input logic [7:0] a, input int c);
		is_ctrl = (c == CH_LEFT) ? (a == ADDR_LEFT_CTRL) : (a == ADDR_RIGHT_CTRL);
	endfunction : is_ctrl

	function automatic logic is_gain(input logic [7:0] a, input int c);
		is_gain = (c == CH_LEFT) ? (a == ADDR_LEFT_GAIN) : (a == ADDR_RIGHT_GAIN);
	endfunction : is_gain

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb
	begin
		next_sense_en = sense_en;
		next_one_rail = one_rail;
		next_balanced = balanced;
		next_unlocked = unlocked;
		next_rdata = rdata;
		if (reg_write && reg_addr == ADDR_DETECT)
		begin
			next_sense_en = {reg_wdata[BIT_STEREO_SENSE], reg_wdata[BIT_LOAD_SENSE]};
		end
		else if (reg_write && reg_addr == ADDR_MODE)
		begin
			next_balanced = reg_wdata[BIT_BALANCED];
			if (unlocked)
			begin
				next_one_rail = reg_wdata[BIT_ONE_RAIL];
			end
		end
		else if (reg_write && reg_addr == ADDR_UNLOCK)
		begin
			next_unlocked = (reg_wdata == UNLOCK_KEY);
		end
		for (int c = 0; c < CHANNELS; c++)
		begin
			next_ctrl[c] = ctrl[c];
			next_gain_code[c] = gain_code[c];
			next_pending[c] = pending[c];
			next_applied[c] = applied[c];
			if (reg_write && is_ctrl(reg_addr, c))
			begin
				next_ctrl[c] = reg_wdata & CTRL_MASK;
			end
			if (ctrl[c][BIT_STEPPING])
			begin
				next_pending[c] = 1'b0;
				if (sample_tick && applied[c] < gain_code[c])
				begin
					next_applied[c] = 6'(applied[c] + GAIN_STEP);
				end
				else if (sample_tick && applied[c] > gain_code[c])
				begin
					next_applied[c] = 6'(applied[c] - GAIN_STEP);
				end
			end
			else if (ctrl[c][BIT_CROSSING])
			begin
				if (pending[c] && crossing[c])
				begin
					next_applied[c] = gain_code[c];
					next_pending[c] = 1'b0;
				end
			end
			else
			begin
				next_applied[c] = gain_code[c];
				next_pending[c] = 1'b0;
			end
			if (reg_write && is_gain(reg_addr, c))
			begin
				next_gain_code[c] = reg_wdata[5:0];
				next_pending[c] = 1'b1;
			end
			next_out_gain[c] = ctrl[c][BIT_FLOOR] ? GAIN_MIN : next_applied[c];
		end
		if (reg_read)
		begin
			if (reg_addr == ADDR_LEFT_CTRL)
			begin
				next_rdata = ctrl[CH_LEFT];
			end
			else if (reg_addr == ADDR_LEFT_GAIN)
			begin
				next_rdata = {2'b00, gain_code[CH_LEFT]};
			end
			else if (reg_addr == ADDR_RIGHT_CTRL)
			begin
				next_rdata = ctrl[CH_RIGHT];
			end
			else if (reg_addr == ADDR_RIGHT_GAIN)
			begin
				next_rdata = {2'b00, gain_code[CH_RIGHT]};
			end
			else if (reg_addr == ADDR_DETECT)
			begin
				next_rdata = BYTE_ZERO;
				next_rdata[BIT_STEREO_SENSE] = sense_en[1];
				next_rdata[BIT_LOAD_SENSE] = sense_en[0];
				next_rdata[BIT_RIGHT_LOAD] = pin_sync[1];
				next_rdata[BIT_LEFT_LOAD] = pin_sync[0];
				next_rdata[BIT_STEREO_STATUS] = pin_sync[2];
			end
			else if (reg_addr == ADDR_MODE)
			begin
				next_rdata = BYTE_ZERO;
				next_rdata[BIT_ONE_RAIL] = one_rail;
				next_rdata[BIT_BALANCED] = balanced;
			end
			else if (reg_addr == ADDR_UNLOCK)
			begin
				next_rdata = BYTE_ZERO;
				next_rdata[BIT_UNLOCKED] = unlocked;
			end
			else
			begin
				next_rdata = BYTE_ZERO;
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int c = 0; c < CHANNELS; c++)
			begin
				ctrl[c] <= CTRL_RESET;
				gain_code[c] <= GAIN_RESET;
				applied[c] <= GAIN_RESET;
				out_gain[c] <= GAIN_RESET;
				pending[c] <= 1'b0;
			end
			sense_en <= 2'b00;
			one_rail <= 1'b0;
			balanced <= 1'b0;
			unlocked <= 1'b0;
			rdata <= BYTE_ZERO;
			pin_meta <= 3'b000;
			pin_sync <= 3'b000;
		end
		else if (clk_en)
		begin
			ctrl <= next_ctrl;
			gain_code <= next_gain_code;
			applied <= next_applied;
			out_gain <= next_out_gain;
			pending <= next_pending;
			sense_en <= next_sense_en;
			one_rail <= next_one_rail;
			balanced <= next_balanced;
			unlocked <= next_unlocked;
			rdata <= next_rdata;
			pin_meta <= {stereo_pin, right_load_pin, left_load_pin};
			pin_sync <= pin_meta;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign reg_rdata = rdata;
	assign left_amp_power = ctrl[CH_LEFT][BIT_POWER];
	assign left_amp_silence = ctrl[CH_LEFT][BIT_SILENCE];
	assign left_output_drive = ctrl[CH_LEFT][BIT_DRIVE];
	assign left_gain_applied = out_gain[CH_LEFT];
	assign right_amp_power = ctrl[CH_RIGHT][BIT_POWER];
	assign right_amp_silence = ctrl[CH_RIGHT][BIT_SILENCE];
	assign right_output_drive = ctrl[CH_RIGHT][BIT_DRIVE];
	assign right_gain_applied = out_gain[CH_RIGHT];
	assign load_sense_on = sense_en[0];
	assign stereo_sense_on = sense_en[1];
	assign one_rail_operation = one_rail;
	assign balanced_output_select = balanced;
endmodule : headphone_amp_control_regs

// File: sim/hp_amp_regs_checker.sv
// Assertion checker for the headphone amplifier control bank
`timescale 1ns/1ps
module hp_amp_regs_checker
	import hp_amp_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic sample_tick,
	input wire logic left_zero_cross,
	input wire logic left_amp_power,
	input wire logic left_output_drive,
	input wire logic [5:0] left_gain_applied,
	input wire logic right_amp_silence,
	input wire logic one_rail_operation,
	input wire logic balanced_output_select
);
	// ********************
	// Properties
	// ********************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic wr;
	assign wr = reg_write && clk_en;
	logic key_seen;
	// Tracks whether the unlock key is currently in force
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			key_seen <= 1'b0;
		end
		else if (wr && reg_addr == ADDR_UNLOCK)
		begin
			key_seen <= (reg_wdata == UNLOCK_KEY);
		end
	end
	a_power_on_write:
		assert property (wr && reg_addr == ADDR_LEFT_CTRL |=> left_amp_power == $past(reg_wdata[7])) else $error("power");
	a_silence_right_bit:
		assert property (wr && reg_addr == ADDR_RIGHT_CTRL |=> right_amp_silence == $past(reg_wdata[6])) else $error("silence");
	a_drive_on_write:
		assert property (wr && reg_addr == ADDR_LEFT_CTRL |=> left_output_drive == $past(reg_wdata[3])) else $error("drive");
	a_floor_gain_held:
		assert property (wr && reg_addr == ADDR_LEFT_CTRL && reg_wdata[2] ##1 clk_en && !reg_write
			|=> left_gain_applied == GAIN_MIN) else $error("floor gain");
	a_balanced_on_write:
		assert property (wr && reg_addr == ADDR_MODE |=> balanced_output_select == $past(reg_wdata[0])) else $error("balanced");
	a_rail_needs_write:
		assert property ($rose(one_rail_operation) |-> $past(wr && reg_addr == ADDR_MODE
			&& reg_wdata[BIT_ONE_RAIL] && key_seen)) else $error("one rail");
	a_unmapped_reads_zero:
		assert property (reg_read && clk_en && reg_addr == 8'hD6 |=> reg_rdata == BYTE_ZERO) else $error("unmapped read");
	a_gain_change_cause:
		assert property ($changed(left_gain_applied) |-> $past(sample_tick) || $past(left_zero_cross)
			|| $past(reg_write, 2) || $past(sys_rst)) else $error("gain change without cause");
endmodule : hp_amp_regs_checker
bind headphone_amp_control_regs hp_amp_regs_checker u_hp_amp_regs_checker (.clk, .sys_rst, .clk_en, .reg_addr,
	.reg_wdata, .reg_write, .reg_read, .reg_rdata, .sample_tick, .left_zero_cross, .left_amp_power,
	.left_output_drive, .left_gain_applied, .right_amp_silence, .one_rail_operation, .balanced_output_select);

// File: sim/hp_load_model.sv
// Headphone load seen at the amplifier outputs
`timescale 1ns/1ps
module hp_load_model
(
	input wire logic plugged,
	output logic left_load_pin,
	output logic right_load_pin,
	output logic stereo_pin
);
	assign left_load_pin = plugged;
	assign right_load_pin = plugged;
	assign stereo_pin = plugged;
endmodule : hp_load_model

// File: sim/headphone_amp_control_regs_tb_top.sv
// Self-checking testbench for the headphone amplifier control bank
`timescale 1ns/1ps
module headphone_amp_control_regs_tb_top
	import hp_amp_pkg::*;
;
	logic clk = 0, sys_rst = 1, clk_en = 1, reg_write = 0, reg_read = 0, sample_tick = 0, left_zero_cross = 0;
	logic plugged = 0, left_load_pin, right_load_pin, stereo_pin, left_amp_power, left_amp_silence;
	logic left_output_drive, right_amp_power, right_amp_silence, right_output_drive;
	logic load_sense_on, stereo_sense_on, one_rail_operation, balanced_output_select;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [5:0] left_gain_applied, right_gain_applied;
	logic right_zero_cross = 0;
	int n_errors = 0, cmp_count = 0, cycles = 0;
	headphone_amp_control_regs u_headphone_amp_control_regs (.*);
	hp_load_model u_hp_load_model (.*);
	// ********************
	// Helpers
	// ********************
	initial forever #2 clk = ~clk;
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk("rdata", exp, reg_rdata);
	endtask : rd
	task automatic gain(input logic [5:0] exp);
		@(posedge clk);
		#1;
		chk("gain", 8'(exp), 8'(left_gain_applied));
	endtask : gain
	task automatic pulse(input logic tick, input logic [5:0] exp);
		@(posedge clk);
		sample_tick <= tick;
		left_zero_cross <= !tick;
		right_zero_cross <= !tick;
		@(posedge clk);
		sample_tick <= 1'b0;
		left_zero_cross <= 1'b0;
		right_zero_cross <= 1'b0;
		#1;
		chk("gain", 8'(exp), 8'(left_gain_applied));
	endtask : pulse
	// ********************
	// Scenarios
	// ********************
	task automatic t_reset();
		rd(ADDR_LEFT_CTRL, 8'h40);
		rd(ADDR_RIGHT_CTRL, 8'h40);
		rd(ADDR_LEFT_GAIN, 8'h3B);
		rd(ADDR_MODE, 8'h00);
	endtask : t_reset
	task automatic t_ctrl();
		wr(ADDR_LEFT_CTRL, 8'h88);
		chk("power", 8'h01, 8'(left_amp_power));
		chk("silence", 8'h00, 8'(left_amp_silence));
		chk("drive", 8'h01, 8'(left_output_drive));
		wr(ADDR_RIGHT_CTRL, 8'hFF);
		rd(ADDR_RIGHT_CTRL, 8'hFC);
		chk("rdrive", 8'h01, 8'(right_output_drive));
		wr(ADDR_RIGHT_GAIN, 8'hFF);
		rd(ADDR_RIGHT_GAIN, 8'h3F);
		chk("rpower", 8'h01, 8'(right_amp_power));
		chk("rsilence", 8'h01, 8'(right_amp_silence));
		chk("rgain", 8'(GAIN_MIN), 8'(right_gain_applied));
	endtask : t_ctrl
	task automatic t_gain();
		wr(ADDR_LEFT_GAIN, 8'h20);
		gain(6'h20);
		wr(ADDR_LEFT_CTRL, 8'h10);
		wr(ADDR_LEFT_GAIN, 8'h25);
		wr(ADDR_LEFT_GAIN, 8'h28);
		gain(6'h20);
		pulse(1'b0, 6'h28);
		wr(ADDR_LEFT_CTRL, 8'h30);
		wr(ADDR_LEFT_GAIN, 8'h2A);
		pulse(1'b0, 6'h28);
		pulse(1'b1, 6'h29);
		pulse(1'b1, 6'h2A);
		pulse(1'b1, 6'h2A);
		wr(ADDR_LEFT_CTRL, 8'h04);
		gain(GAIN_MIN);
	endtask : t_gain
	task automatic t_mode();
		wr(ADDR_MODE, 8'h11);
		rd(ADDR_MODE, 8'h01);
		wr(ADDR_UNLOCK, UNLOCK_KEY);
		wr(ADDR_MODE, 8'h11);
		rd(ADDR_MODE, 8'h11);
		chk("rail", 8'h01, 8'(one_rail_operation));
		chk("balanced", 8'h01, 8'(balanced_output_select));
		rd(8'hD6, BYTE_ZERO);
	endtask : t_mode
	task automatic t_load();
		plugged <= 1'b1;
		wr(ADDR_DETECT, 8'hC0);
		chk("stereo sense", 8'h01, 8'(stereo_sense_on));
		rd(ADDR_DETECT, 8'hC7);
		chk("sense", 8'h01, 8'(load_sense_on));
		plugged <= 1'b0;
		wr(ADDR_DETECT, 8'h07);
		rd(ADDR_DETECT, 8'h00);
	endtask : t_load
	task automatic t_hold();
		@(posedge clk);
		clk_en <= 1'b0;
		wr(ADDR_LEFT_CTRL, 8'h80);
		@(posedge clk);
		clk_en <= 1'b1;
		chk("held power", 8'h00, 8'(left_amp_power));
		rd(ADDR_LEFT_CTRL, 8'h04);
	endtask : t_hold
	task automatic t_rerun();
		@(posedge clk);
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk("rst gain", 8'(GAIN_RESET), 8'(left_gain_applied));
		chk("rst silence", 8'h01, 8'(left_amp_silence));
		chk("rst rail", 8'h00, 8'(one_rail_operation));
		t_reset();
		wr(ADDR_MODE, 8'h10);
		rd(ADDR_MODE, 8'h00);
	endtask : t_rerun
	task automatic results();
		$display("Checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_errors++;
			results();
		end
	end
	initial
	begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_ctrl();
		t_gain();
		t_mode();
		t_load();
		t_hold();
		t_rerun();
		results();
	end
endmodule : headphone_amp_control_regs_tb_top
